// ===== common/iitc_params.svh
// Purpose: Timing counts and field positions for the interrupt/trap block.
// Assumes: 125 MHz clock; sequence times taken as nanoseconds.
// Notes:   Header of definitions only.
`ifndef IITC_PARAMS_SVH
`define IITC_PARAMS_SVH
`define IITC_ADDR_W       16
`define IITC_CLK_NS       8
`define IITC_ZERO_ADDR    16'h0000
// ----------------------------------------------------------------
// Sequence lengths and sample times in time units, then their cycle counts.
// ----------------------------------------------------------------
`define IITC_INT_END_NS   3350
`define IITC_TIN_END_NS   2950
`define IITC_TOUT_END_NS  2950
`define IITC_ADDR_NS      600
`define IITC_DATA_NS      1900
`define IITC_INT_CYC  (`IITC_INT_END_NS / `IITC_CLK_NS)
`define IITC_TIN_CYC  (`IITC_TIN_END_NS / `IITC_CLK_NS)
`define IITC_TOUT_CYC (`IITC_TOUT_END_NS / `IITC_CLK_NS)
`define IITC_ADDR_CYC ((`IITC_ADDR_NS + `IITC_CLK_NS - 1) / `IITC_CLK_NS)
`define IITC_DATA_CYC ((`IITC_DATA_NS + `IITC_CLK_NS - 1) / `IITC_CLK_NS)
`endif

// ===== common/iitc_pkg.sv
// Purpose: Types shared by the interrupt/trap block.
// Assumes: Nothing beyond the header.
// Notes:   States of the sequencer.
package iitc_pkg;
   typedef enum logic [1:0] {
      IITC_IDLE,
      IITC_INT,
      IITC_TIN,
      IITC_TOUT
   } iitc_state_e;
   typedef logic [15:0] iitc_word_t;
endpackage

// ===== hdl/iitc_ctrl.sv
// Purpose: Recognise I/O bus interrupt and trap requests and sequence them.
// Assumes: Inputs synchronous to clk_in; bus lines read as a level.
// Notes:   The CPU core acts on the one-cycle command pulses this makes.
`include "iitc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module iitc_ctrl
   import iitc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        program_interrupt_request_in,
   input  wire logic        trap_in_request_in,
   input  wire logic        trap_out_request_in,
   input  wire logic        jump_mark_indicator_in,
   input  wire logic        addr_driven_in,
   input  wire iitc_word_t  io_bus_data_lines_in,
   input  wire logic        jump_taken_in,
   input  wire logic        io_transfer_in,
   input  wire logic        external_control_instr_in,
   input  wire logic        increment_replace_access_in,
   input  wire logic        step_active_in,
   input  wire logic        halted_in,
   output logic             branch_out,
   output logic             branch_mark_out,
   output iitc_word_t       branch_addr_out,
   output logic             mem_write_out,
   output logic             mem_read_out,
   output iitc_word_t       mem_addr_out,
   output iitc_word_t       mem_wdata_out,
   output logic             busy_out
);
   // ----------------------------------------------------------------
   // Recognition gating.
   // ----------------------------------------------------------------
   iitc_state_e state_r;                  // Sequencer state.
   logic [15:0] cnt_r;                    // Cycles into the sequence.
   logic        exc_after_r;              // Cycle after a control instr.
   logic        int_ok;                   // Interrupt may be recognised.
   logic        trap_ok;                  // Trap may be recognised.

   // One cycle of trap inhibit follows each external control cycle.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         exc_after_r <= 1'b0;
      end else begin
         exc_after_r <= external_control_instr_in;
      end
   end

   // Requests are levels held by the controller, so an inhibited one
   // simply waits on its line and is seen at the first free cycle.
   always_comb begin
      int_ok  = (state_r == IITC_IDLE) && !jump_taken_in;
      trap_ok = (state_r == IITC_IDLE) && !io_transfer_in
                && !external_control_instr_in && !exc_after_r
                && !increment_replace_access_in
                && !step_active_in && !halted_in;
   end

   // ----------------------------------------------------------------
   // Sequencer.
   // ----------------------------------------------------------------
   // Traps win over the interrupt since they finish sooner and need
   // no software help; the interrupt line is shared by all controllers.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_r <= IITC_IDLE;
         cnt_r   <= 16'h0000;
      end else begin
         unique case (state_r)
            IITC_IDLE: begin
               cnt_r <= 16'h0000;
               if (trap_ok && trap_in_request_in) begin
                  state_r <= IITC_TIN;
               end else if (trap_ok && trap_out_request_in) begin
                  state_r <= IITC_TOUT;
               end else if (int_ok && program_interrupt_request_in) begin
                  state_r <= IITC_INT;
               end
            end
            IITC_INT: begin
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r == 16'(`IITC_INT_CYC)) begin
                  state_r <= IITC_IDLE;
               end
            end
            IITC_TIN: begin
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r == 16'(`IITC_TIN_CYC)) begin
                  state_r <= IITC_IDLE;
               end
            end
            IITC_TOUT: begin
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r == 16'(`IITC_TOUT_CYC)) begin
                  state_r <= IITC_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs: sampled bus values and one-cycle command pulses.
   // ----------------------------------------------------------------
   // Address and data are sampled at their latest valid times.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         branch_out      <= 1'b0;
         branch_mark_out <= 1'b0;
         branch_addr_out <= 16'h0000;
         mem_write_out   <= 1'b0;
         mem_read_out    <= 1'b0;
         mem_addr_out    <= 16'h0000;
         mem_wdata_out   <= 16'h0000;
         busy_out        <= 1'b0;
      end else begin
         branch_out    <= 1'b0;
         mem_write_out <= 1'b0;
         mem_read_out  <= 1'b0;
         busy_out      <= (state_r != IITC_IDLE);
         if (state_r == IITC_INT && cnt_r == 16'(`IITC_ADDR_CYC)) begin
            branch_out      <= 1'b1;
            branch_mark_out <= jump_mark_indicator_in;
            branch_addr_out <= addr_driven_in ? io_bus_data_lines_in
                                              : `IITC_ZERO_ADDR;
         end
         if ((state_r == IITC_TIN || state_r == IITC_TOUT)
             && cnt_r == 16'(`IITC_ADDR_CYC)) begin
            mem_addr_out <= io_bus_data_lines_in;
            mem_read_out <= (state_r == IITC_TOUT);
         end
         if (state_r == IITC_TIN && cnt_r == 16'(`IITC_DATA_CYC)) begin
            mem_wdata_out <= io_bus_data_lines_in;
            mem_write_out <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   // An interrupt seen during a taken jump must not start the interrupt sequence.
   a_no_int_jump: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (state_r == IITC_IDLE && jump_taken_in)
      |=> state_r != IITC_INT)
      else $error("interrupt recognised during taken jump");
   // Both the transfer cycle and the cycle after a control instruction
   // must keep traps out; the sampled past covers the trailing cycle.
   a_no_trap_exc: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (state_r == IITC_IDLE && (io_transfer_in
       || external_control_instr_in || $past(external_control_instr_in)))
      |=> !(state_r inside {IITC_TIN, IITC_TOUT}))
      else $error("trap recognised near control instruction");
   // No trap may start while an operand is being replaced.
   a_no_trap_inr: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (state_r == IITC_IDLE && increment_replace_access_in)
      |=> !(state_r inside {IITC_TIN, IITC_TOUT}))
      else $error("trap recognised during operand access");
   // A halted or stepping processor takes no trap.
   a_no_trap_halt: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (state_r == IITC_IDLE && (halted_in || step_active_in))
      |=> !(state_r inside {IITC_TIN, IITC_TOUT}))
      else $error("trap recognised while halted or stepping");
   // A taken interrupt that no trap outranks branches near time 600.
   a_int_branch: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (state_r == IITC_IDLE && $past(state_r) == IITC_IDLE
       && int_ok && program_interrupt_request_in
       && !(trap_ok && (trap_in_request_in || trap_out_request_in)))
      |=> ##[75:77] branch_out)
      else $error("interrupt did not branch in time");
   // An undriven interrupt address must come out as zero.
   a_zero_addr: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (state_r == IITC_INT && cnt_r == 16'(`IITC_ADDR_CYC)
       && !addr_driven_in)
      |=> branch_addr_out == `IITC_ZERO_ADDR)
      else $error("undriven interrupt address not zero");
   // A trap-in writes its word once the data time has passed.
   a_tin_write: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $rose(state_r == IITC_TIN) |-> ##[237:239] mem_write_out)
      else $error("trap-in did not write memory");
   // A trap-out reads its word once the address time has passed.
   a_tout_read: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $rose(state_r == IITC_TOUT) |-> ##[75:77] mem_read_out)
      else $error("trap-out did not read memory");
   // A trap-in that is no longer inhibited is taken at once.
   a_pending: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (state_r == IITC_IDLE && trap_ok && trap_in_request_in)
      |=> state_r == IITC_TIN)
      else $error("pending trap-in not taken when allowed");
   // Main scenarios: both interrupt flavours, both traps, a held trap.
   c_int: cover property (@(posedge clk_in) branch_out && branch_mark_out);
   c_zero: cover property (@(posedge clk_in) branch_out
      && branch_addr_out == `IITC_ZERO_ADDR);
   c_tin: cover property (@(posedge clk_in) mem_write_out);
   c_tout: cover property (@(posedge clk_in) mem_read_out);
   c_held: cover property (@(posedge clk_in) state_r == IITC_IDLE
      && trap_in_request_in && !trap_ok);
endmodule
`default_nettype wire

// ===== bench/iitc_periph_model.sv
// Purpose: Peripheral controller model that raises requests on the I/O bus.
// Assumes: The bench commands one request at a time with a go pulse.
// Notes:   Times count busy cycles, one later than sequence start.
`timescale 1ns/1ps
`default_nettype none
module iitc_periph_model
   import iitc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        go_in,
   input  wire iitc_state_e kind_in,
   input  wire iitc_word_t  addr_in,
   input  wire iitc_word_t  data_in,
   input  wire logic        busy_in,
   input  wire logic        sense_in,
   output logic             int_req_out,
   output logic             tin_req_out,
   output logic             tout_req_out,
   output iitc_word_t       bus_out,
   output logic             sense_response_line_out
);
   // ----------------------------------------------------------------
   // Request state.
   // ----------------------------------------------------------------
   iitc_state_e kind_r;  // Kind of request under way.
   logic        act_r;   // High from the first go; only reset clears it.
   logic [9:0]  cnt_r;   // Busy cycles seen since go.
   iitc_word_t  last_r;  // Last value that was driven.
   logic        bus_on;  // High while the bus is driven.
   // Requests drop at 3200, 2700 and 2750 units.
   assign int_req_out  = act_r && kind_r == IITC_INT && cnt_r < 10'h190;
   assign tin_req_out  = act_r && kind_r == IITC_TIN && cnt_r < 10'h151;
   assign tout_req_out = act_r && kind_r == IITC_TOUT && cnt_r < 10'h157;
   // Address to 1400 (interrupt address to 3200), trap-in data to 2750.
   // All trap data is off the bus before time 2900; the interrupt address stays on it to 3200.
   assign bus_on = act_r && (cnt_r < 10'h0AF
      || (kind_r == IITC_TIN && cnt_r < 10'h157)
      || (kind_r == IITC_INT && cnt_r < 10'h190));
   // A released bus shows a changed value so no stale word can pass.
   assign bus_out = !bus_on ? ~last_r :
      (kind_r == IITC_TIN && cnt_r >= 10'h0AF) ? data_in : addr_in;
   // Counting stands still while a request waits unrecognised.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         act_r  <= 1'b0;
         cnt_r  <= 10'h000;
         kind_r <= IITC_IDLE;
         last_r <= 16'h0000;
      end else begin
         if (go_in) begin
            act_r  <= 1'b1;
            cnt_r  <= 10'h000;
            kind_r <= kind_in;
         end else if (act_r && busy_in) begin
            cnt_r <= cnt_r + 10'h001;
         end
         if (bus_on) begin
            last_r <= bus_out;
         end
      end
   end
   // A peripheral whose condition is true answers a sense one cycle into
   // the execute phase, far inside the 780 limit.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         sense_response_line_out <= 1'b0;
      end else begin
         sense_response_line_out <= sense_in;
      end
   end
endmodule
`default_nettype wire

// ===== bench/io_interrupt_trap_control_test.sv
// Purpose: Self-checking bench for the interrupt and trap sequencer.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Each scenario is its own task and judges its own outcome.
`timescale 1ns/1ps
`default_nettype none
module io_interrupt_trap_control_test;
   import iitc_pkg::*;
   logic clk_in, sys_rst_in, go, jmark, drv, br_o, mk_o, wr_o, rd_o, busy;
   logic ir, ti, to;           // Request lines from the model.
   logic sns, srl;             // Sense pulse and the model's answer.
   logic [5:0]  st;            // CPU status levels that inhibit.
   iitc_state_e kind;          // Kind commanded to the model.
   iitc_word_t  a, d, bus, ba, ma, wd;
   int errors, comparisons, cyc, nbr, n;
   wire [4:0] ev = {busy, ~busy, rd_o, wr_o, br_o}; // Awaitable events.
   iitc_ctrl uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .program_interrupt_request_in(ir), .trap_in_request_in(ti),
      .trap_out_request_in(to), .jump_mark_indicator_in(jmark),
      .addr_driven_in(drv), .io_bus_data_lines_in(bus),
      .jump_taken_in(st[0]), .io_transfer_in(st[1]),
      .external_control_instr_in(st[2]),
      .increment_replace_access_in(st[3]), .step_active_in(st[4]),
      .halted_in(st[5]), .branch_out(br_o), .branch_mark_out(mk_o),
      .branch_addr_out(ba), .mem_write_out(wr_o), .mem_read_out(rd_o),
      .mem_addr_out(ma), .mem_wdata_out(wd), .busy_out(busy));
   iitc_periph_model ctl (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .go_in(go), .kind_in(kind), .addr_in(a), .data_in(d),
      .busy_in(busy), .sense_in(sns), .int_req_out(ir), .tin_req_out(ti),
      .tout_req_out(to), .bus_out(bus), .sense_response_line_out(srl));
   // ----------------------------------------------------------------
   // Clock, branch counter and a cycle ceiling against hangs.
   // ----------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      if (br_o === 1'b1) nbr++;
      cyc++;
      if (cyc == 12000) begin
         errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("counts: %0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Waits a bounded time for one event; 500 covers the longest sequence.
   task automatic wait_ev(input int s);
      for (n = 1; n < 500 && ev[s] !== 1'b1; n++) begin
         @(posedge clk_in);
         #1;
      end
      // A wait that runs out counts as a mismatch, so a hang cannot pass.
      if (ev[s] !== 1'b1) begin
         errors++;
         $display("mismatch event %0d expected 1 seen 0", s);
      end
   endtask
   task automatic start(input iitc_state_e k, input iitc_word_t ad,
                        input iitc_word_t dt);
      kind = k; a = ad; d = dt; go = 1'b1;
      @(posedge clk_in);
      #1 go = 1'b0;
   endtask
   // Event index: 0 branch, 1 write, 2 read, 3 idle again, 4 busy.
   task automatic t_int(input logic dv, input logic mk,
                        input iitc_word_t ad, input iitc_word_t ex);
      drv = dv;
      jmark = mk;
      start(IITC_INT, ad, 16'hA5A5);
      wait_ev(0);
      chk("branch latency", 16'h0001,
          {15'h0000, n >= 74 && n <= 80});
      chk("branch address", ex, ba);
      chk("branch mark", {15'h0000, mk}, {15'h0000, mk_o});
      wait_ev(3);
      repeat (5) @(posedge clk_in);
      #1;
      chk("busy after end", 16'h0000, {15'h0000, busy});
      $display("interrupt test done");
   endtask
   task automatic t_trap(input iitc_state_e k, input iitc_word_t ad,
                         input iitc_word_t dt);
      int b0;
      b0 = nbr;
      start(k, ad, dt);
      wait_ev(k == IITC_TIN ? 1 : 2);
      chk("trap address", ad, ma);
      if (k == IITC_TIN) begin
         chk("trap data", dt, wd);
      end
      wait_ev(3);
      repeat (5) @(posedge clk_in);
      #1;
      chk("branches in trap", 16'h0000, 16'(nbr - b0));
      chk("busy after trap", 16'h0000, {15'h0000, busy});
      $display("trap test done");
   endtask
   task automatic t_inh(input int b, input iitc_state_e k);
      st[b] = 1'b1;
      start(k, 16'h0042, 16'h0099);
      repeat (40) @(posedge clk_in);
      #1;
      chk("busy inhibited", 16'h0000, {15'h0000, busy});
      st = 6'h00;
      wait_ev(4);
      chk("pending taken", 16'h0001, {15'h0000, n <= 4});
      wait_ev(3);
      repeat (2) @(posedge clk_in);
      #1;
      $display("inhibit test done");
   endtask
   // A true condition must answer a sense well inside 780 units.
   task automatic t_sense();
      sns = 1'b1;
      @(posedge clk_in);
      #1;
      sns = 1'b0;
      chk("sense response", 16'h0001, {15'h0000, srl});
      @(posedge clk_in);
      #1;
      chk("sense released", 16'h0000, {15'h0000, srl});
      $display("sense test done");
   endtask
   initial begin
      sys_rst_in = 1'b1; go = 1'b0; kind = IITC_IDLE; a = 16'h0000;
      d = 16'h0000; st = 6'h00; drv = 1'b1; jmark = 1'b0;
      sns = 1'b0;
      repeat (16) @(posedge clk_in);
      #1 sys_rst_in = 1'b0;
      chk("busy reset", 16'h0000, {15'h0000, busy});
      t_sense();
      t_int(1'b1, 1'b1, 16'h1234, 16'h1234);
      t_int(1'b0, 1'b0, 16'h0F0F, 16'h0000);
      t_trap(IITC_TIN, 16'h0456, 16'hBEEF);
      t_trap(IITC_TOUT, 16'h7FFF, 16'h0000);
      t_inh(0, IITC_INT);
      for (int b = 1; b < 6; b++) t_inh(b, IITC_TIN);
      wrap_up();
   end
endmodule
`default_nettype wire
